// ===== core/xfer_pkg.sv
`default_nettype none
package xfer_pkg;
  // ==========================================================
  // Widths
  localparam int NIB_W   = 4;
  localparam int BYTE_W  = 8;
  localparam int ADC_W   = 10;
  localparam int ROM_W   = 10;
  localparam int PTR_W   = 3;
  localparam int PAGE_W  = 6;
  localparam int ROM_AW  = PAGE_W + PTR_W + NIB_W;
  // ==========================================================
  // Field positions
  localparam int ADC_HI_MSB   = 9;
  localparam int ADC_MID_MSB  = 5;
  localparam int ROM_PTR_MSB  = 9;
  localparam int ROM_BYTE_MSB = 7;
  // ==========================================================
  // Mode select value meaning comparator mode
  localparam logic MODE_COMPARE = 1'b1;
  // Reset value of nibble outputs
  localparam logic [3:0] NIB_RST = 4'h0;
  // ==========================================================
  // Instruction codes of this group
  typedef enum logic [3:0] {
    OP_LOAD_T2   = 4'h0,
    OP_LOAD_T3   = 4'h1,
    OP_LOAD_T4   = 4'h2,
    OP_COPY_AUX  = 4'h3,
    OP_READ_T1   = 4'h4,
    OP_READ_T2   = 4'h5,
    OP_READ_T3   = 4'h6,
    OP_READ_T4   = 4'h7,
    OP_READ_CONV = 4'h8,
    OP_WR_CMPREF = 4'h9,
    OP_READ_EXT  = 4'hA,
    OP_READ_ROM  = 4'hB,
    OP_READ_SER  = 4'hC,
    OP_READ_PTR  = 4'hD
  } op_t;
  // ==========================================================
  // Nibble pair: aux is the upper half, acc the lower
  typedef struct packed {
    logic [3:0] aux;
    logic [3:0] acc;
  } nib_pair_t;
  // Peripheral values read by this group
  typedef struct packed {
    logic [3:0][7:0] timer;
    logic [9:0]      conv;
    logic [7:0]      ext;
    logic [7:0]      ser;
  } periph_t;
endpackage
`default_nettype wire

// ===== core/rom_table_seq.sv
`default_nettype none
module rom_table_seq (
  input  wire logic                          sys_clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          start_i,
  input  wire logic [xfer_pkg::PAGE_W-1:0]   page_i,
  input  wire logic [xfer_pkg::PTR_W-1:0]    ptr_i,
  input  wire logic [xfer_pkg::NIB_W-1:0]    acc_i,
  input  wire logic [xfer_pkg::ROM_W-1:0]    rom_data_i,
  output logic                               rom_rd_o,
  output logic [xfer_pkg::ROM_AW-1:0]        rom_addr_o,
  output logic                               push_o,
  output logic                               pop_o,
  output logic                               busy_o,
  output logic                               fin_o,
  output logic [xfer_pkg::ROM_W-1:0]         word_o
);
  // ==========================================================
  // Three-cycle sequence: push, read, pop
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PUSH = 2'b01,
    S_READ = 2'b10,
    S_POP  = 2'b11
  } seq_t;

  seq_t                       state_reg, state_next;
  logic [xfer_pkg::ROM_AW-1:0] addr_reg;
  logic [xfer_pkg::ROM_W-1:0]  word_reg;

  // Next state
  always_comb begin
    case (state_reg)
      S_IDLE:  state_next = start_i ? S_PUSH : S_IDLE;
      S_PUSH:  state_next = S_READ;
      S_READ:  state_next = S_POP;
      S_POP:   state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // State, address latch and ROM word capture
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= S_IDLE;
      addr_reg  <= '0;
      word_reg  <= '0;
    end else begin
      state_reg <= state_next;
      if (start_i && state_reg == S_IDLE) addr_reg <= {page_i, ptr_i, acc_i};
      if (state_reg == S_READ) word_reg <= rom_data_i;
    end
  end

  // Stack and ROM strobes
  assign push_o     = (state_reg == S_PUSH);
  assign rom_rd_o   = (state_reg == S_PUSH);
  assign pop_o      = (state_reg == S_POP);
  assign fin_o      = (state_reg == S_POP);
  assign busy_o     = (state_reg != S_IDLE);
  assign rom_addr_o = addr_reg;
  assign word_o     = word_reg;
endmodule
`default_nettype wire

// ===== core/xfer_exec.sv
// Contract
// - Load timer 2 and its reload: aux upper nibble, acc lower nibble.
// - Load timer 3 and its reload together: aux upper, acc lower.
// - Load timer 4 and primary reload together: aux upper, acc lower.
// - Timer reads: upper count nibble to aux, lower to acc.
// - Conversion mode read: result bits 9..6 to aux, 5..2 to acc.
// - Comparator mode read: result bits 7..4 to aux, 3..0 to acc.
// - Compare reference write: no-op in conversion mode, else aux:acc loaded.
// - Extra register read: bits 7..4 to aux, 3..0 to acc.
// - ROM read at page,pointer,acc; bits 9..8 to pointer, top cleared.
// - Serial shift read: upper nibble to aux, lower to acc.
// - Pointer read: pointer to acc bits 2..0, bit 3 zero.
`default_nettype none
module xfer_exec (
  input  wire logic                          sys_clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          op_valid_i,
  input  wire xfer_pkg::op_t                 op_i,
  input  wire logic [xfer_pkg::PAGE_W-1:0]   page_i,
  input  wire xfer_pkg::nib_pair_t           regs_i,
  input  wire logic [xfer_pkg::PTR_W-1:0]    ptr_i,
  input  wire logic                          compare_mode_select_i,
  input  wire xfer_pkg::periph_t             periph_i,
  input  wire logic [xfer_pkg::ROM_W-1:0]    rom_data_i,
  output logic                               busy_o,
  output logic                               done_o,
  output logic                               regs_we_acc_o,
  output logic                               regs_we_aux_o,
  output xfer_pkg::nib_pair_t                regs_o,
  output logic                               load_second_timer_o,
  output logic                               load_third_timer_o,
  output logic                               load_fourth_timer_o,
  output logic                               load_cmp_ref_o,
  output logic [xfer_pkg::BYTE_W-1:0]        load_data_o,
  output logic                               ptr_we_o,
  output logic [xfer_pkg::PTR_W-1:0]         ptr_o,
  output logic                               rom_rd_o,
  output logic [xfer_pkg::ROM_AW-1:0]        rom_addr_o,
  output logic                               stack_push_o,
  output logic                               stack_pop_o
);
  // ==========================================================
  // Decode
  logic                       seq_busy;
  logic                       seq_fin;
  logic [xfer_pkg::ROM_W-1:0] rom_word;
  wire  go      = op_valid_i && !seq_busy;
  wire  is_cmp  = (compare_mode_select_i == xfer_pkg::MODE_COMPARE);
  wire  rd_rom  = go && (op_i == xfer_pkg::OP_READ_ROM);
  wire  [7:0] ab_byte = {regs_i.aux, regs_i.acc};

  // Selects the byte returned by single-cycle reads
  function automatic logic [7:0] read_byte(input xfer_pkg::op_t op, input xfer_pkg::periph_t p,
                                           input logic cmp, input xfer_pkg::nib_pair_t r,
                                           input logic [2:0] ptr);
    case (op)
      xfer_pkg::OP_READ_T1:   read_byte = p.timer[0];
      xfer_pkg::OP_READ_T2:   read_byte = p.timer[1];
      xfer_pkg::OP_READ_T3:   read_byte = p.timer[2];
      xfer_pkg::OP_READ_T4:   read_byte = p.timer[3];
      xfer_pkg::OP_READ_CONV: read_byte = cmp ? p.conv[7:0]
                                              : p.conv[xfer_pkg::ADC_HI_MSB:2];
      xfer_pkg::OP_READ_EXT:  read_byte = p.ext;
      xfer_pkg::OP_READ_SER:  read_byte = p.ser;
      xfer_pkg::OP_COPY_AUX:  read_byte = {r.aux, r.aux};
      xfer_pkg::OP_READ_PTR:  read_byte = {4'h0, 1'b0, ptr};
      default:                read_byte = 8'h00;
    endcase
  endfunction

  // Which registers the single-cycle reads write
  wire  is_read  = go && (op_i inside {xfer_pkg::OP_READ_T1, xfer_pkg::OP_READ_T2, xfer_pkg::OP_READ_T3,
                                       xfer_pkg::OP_READ_T4, xfer_pkg::OP_READ_CONV, xfer_pkg::OP_READ_EXT,
                                       xfer_pkg::OP_READ_SER});
  wire  acc_only = go && (op_i inside {xfer_pkg::OP_COPY_AUX, xfer_pkg::OP_READ_PTR});
  wire  [7:0] rd_byte = read_byte(op_i, periph_i, is_cmp, regs_i, ptr_i);

  // Next values of the register-file write port
  xfer_pkg::nib_pair_t regs_next;
  logic                we_acc_next, we_aux_next;
  assign we_acc_next = is_read || acc_only || seq_fin;
  assign we_aux_next = is_read || seq_fin;
  assign regs_next   = seq_fin ? xfer_pkg::nib_pair_t'(rom_word[xfer_pkg::ROM_BYTE_MSB:0])
                               : xfer_pkg::nib_pair_t'(rd_byte);

  // Peripheral load strobes
  wire  ld_t2  = go && (op_i == xfer_pkg::OP_LOAD_T2);
  wire  ld_t3  = go && (op_i == xfer_pkg::OP_LOAD_T3);
  wire  ld_t4  = go && (op_i == xfer_pkg::OP_LOAD_T4);
  wire  ld_cmp = go && (op_i == xfer_pkg::OP_WR_CMPREF) && is_cmp;
  wire  one_cy = go && (op_i != xfer_pkg::OP_READ_ROM);

  // ==========================================================
  // ROM table read sequencer
  rom_table_seq u_seq (
    .sys_clk_i  (sys_clk_i),
    .sys_rst_i  (sys_rst_i),
    .start_i    (rd_rom),
    .page_i     (page_i),
    .ptr_i      (ptr_i),
    .acc_i      (regs_i.acc),
    .rom_data_i (rom_data_i),
    .rom_rd_o   (rom_rd_o),
    .rom_addr_o (rom_addr_o),
    .push_o     (stack_push_o),
    .pop_o      (stack_pop_o),
    .busy_o     (seq_busy),
    .fin_o      (seq_fin),
    .word_o     (rom_word)
  );
  assign busy_o = seq_busy;

  // ==========================================================
  // Registered outputs
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      regs_o              <= '0;
      regs_we_acc_o       <= 1'b0;
      regs_we_aux_o       <= 1'b0;
      load_second_timer_o <= 1'b0;
      load_third_timer_o  <= 1'b0;
      load_fourth_timer_o <= 1'b0;
      load_cmp_ref_o      <= 1'b0;
      load_data_o         <= '0;
      ptr_we_o            <= 1'b0;
      ptr_o               <= '0;
      done_o              <= 1'b0;
    end else begin
      regs_o              <= regs_next;
      regs_we_acc_o       <= we_acc_next;
      regs_we_aux_o       <= we_aux_next;
      load_second_timer_o <= ld_t2;
      load_third_timer_o  <= ld_t3;
      load_fourth_timer_o <= ld_t4;
      load_cmp_ref_o      <= ld_cmp;
      load_data_o         <= ab_byte;
      ptr_we_o            <= seq_fin;
      ptr_o               <= {1'b0, rom_word[xfer_pkg::ROM_PTR_MSB:8]};
      done_o              <= one_cy || seq_fin;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Peripheral loads
  a_timer2_load: assert property (ld_t2 |=> load_second_timer_o && load_data_o == $past(ab_byte))
    else $error("timer 2 load wrong");
  a_timer3_load: assert property (ld_t3 |=>
                                  load_third_timer_o && !load_second_timer_o && load_data_o == $past(ab_byte))
    else $error("timer 3 load wrong");
  a_timer4_load: assert property (ld_t4 |=> load_fourth_timer_o && load_data_o == $past(ab_byte))
    else $error("timer 4 load wrong");
  a_load_onehot: assert property ($onehot0({ld_t2, ld_t3, ld_t4, ld_cmp}))
    else $error("several load strobes at once");
  a_load_data: assert property (go |=> load_data_o == $past(ab_byte))
    else $error("load data not aux and acc");

  // Register reads, compare reference write, table sequence and single-cycle completion
  a_copy_aux: assert property (go && op_i == xfer_pkg::OP_COPY_AUX |=>
                               regs_we_acc_o && !regs_we_aux_o && regs_o.acc == $past(regs_i.aux))
    else $error("aux copy wrong");
  a_timer_read: assert property (go && op_i == xfer_pkg::OP_READ_T3 |=>
                                 regs_we_aux_o && regs_o == $past(periph_i.timer[2]))
    else $error("timer read wrong");
  a_conv_read: assert property (go && op_i == xfer_pkg::OP_READ_CONV && !is_cmp |=>
                                regs_o == $past(periph_i.conv[9:2]))
    else $error("conversion read wrong");
  a_cmp_read: assert property (go && op_i == xfer_pkg::OP_READ_CONV && is_cmp |=>
                               regs_o == $past(periph_i.conv[7:0]))
    else $error("comparator read wrong");
  a_cmpref_noop: assert property (go && op_i == xfer_pkg::OP_WR_CMPREF |=>
                                  load_cmp_ref_o == $past(is_cmp) && load_data_o == $past(ab_byte))
    else $error("compare reference load wrong");
  a_rom_seq: assert property (rd_rom |=> stack_push_o ##1 busy_o ##1 (stack_pop_o && busy_o) ##1
                              (ptr_we_o && done_o && !busy_o))
    else $error("rom read sequence wrong");
  a_rom_ptr: assert property (ptr_we_o |-> ptr_o[2] == 1'b0 && regs_we_aux_o)
    else $error("pointer update wrong");
  a_ptr_read: assert property (go && op_i == xfer_pkg::OP_READ_PTR |=>
                               regs_o.acc == {1'b0, $past(ptr_i)} && !regs_we_aux_o)
    else $error("pointer read wrong");
  a_one_cycle: assert property (one_cy |=> done_o && !busy_o)
    else $error("single cycle transfer wrong");

  // Remaining reads, table fetch and quiet cycles
  a_timer1_read: assert property (go && op_i == xfer_pkg::OP_READ_T1 |=>
                                  regs_we_aux_o && regs_we_acc_o && regs_o == $past(periph_i.timer[0]))
    else $error("timer 1 read wrong");
  a_timer2_read: assert property (go && op_i == xfer_pkg::OP_READ_T2 |=>
                                  regs_we_aux_o && regs_we_acc_o && regs_o == $past(periph_i.timer[1]))
    else $error("timer 2 read wrong");
  a_timer4_read: assert property (go && op_i == xfer_pkg::OP_READ_T4 |=>
                                  regs_we_aux_o && regs_we_acc_o && regs_o == $past(periph_i.timer[3]))
    else $error("timer 4 read wrong");
  a_ext_read: assert property (go && op_i == xfer_pkg::OP_READ_EXT |=>
                               regs_we_aux_o && regs_we_acc_o && regs_o == $past(periph_i.ext))
    else $error("extra register read wrong");
  a_ser_read: assert property (go && op_i == xfer_pkg::OP_READ_SER |=>
                               regs_we_aux_o && regs_we_acc_o && regs_o == $past(periph_i.ser))
    else $error("serial shift read wrong");
  a_rom_addr: assert property (stack_push_o |->
                               rom_rd_o && rom_addr_o == $past({page_i, ptr_i, regs_i.acc}))
    else $error("table address wrong");
  a_rom_data: assert property (ptr_we_o |->
                               regs_o == $past(rom_data_i[7:0], 2) && ptr_o[1:0] == $past(rom_data_i[9:8], 2))
    else $error("table data wrong");
  a_busy_quiet: assert property (busy_o |=>
      !load_second_timer_o && !load_third_timer_o && !load_fourth_timer_o && !load_cmp_ref_o)
    else $error("load strobe during table read");
  a_idle_quiet: assert property (!op_valid_i && !busy_o |=>
                                 !done_o && !regs_we_acc_o && !regs_we_aux_o)
    else $error("write without instruction");

  // Main scenarios
  c_rom_read:  cover property (rd_rom ##4 done_o);
  c_cmp_write: cover property (ld_cmp);
  c_conv_read: cover property (go && op_i == xfer_pkg::OP_READ_CONV && !is_cmp);
  c_load_t4:   cover property (ld_t4);
  c_tmr_read:  cover property (go && op_i == xfer_pkg::OP_READ_T1);
endmodule
`default_nettype wire

// ===== verif/test_xfer_exec.sv
`default_nettype none
module test_xfer_exec;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus and observation signals
  logic                sys_clk_i, sys_rst_i, op_valid_i, mode_sel;
  xfer_pkg::op_t       op_i;
  xfer_pkg::nib_pair_t regs_i, regs_o;
  xfer_pkg::periph_t   periph_i;
  logic [5:0]          page_i;
  logic [2:0]          ptr_i, ptr_o, s_ptr;
  logic [9:0]          rom_data_i;
  logic                busy_o, done_o, we_acc, we_aux, ld2, ld3, ld4, ldc, ptr_we_o, rom_rd_o, push, pop, s_pwe;
  logic [7:0]          load_data_o, s_regs, s_ldata;
  logic [12:0]         rom_addr_o, s_addr;
  logic [1:0]          s_we;
  logic [3:0]          s_ld;
  int                  mismatches, tests_run, lat, n_push, n_pop, n_busy;

  xfer_exec dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .page_i(page_i), .regs_i(regs_i), .ptr_i(ptr_i), .compare_mode_select_i(mode_sel), .periph_i(periph_i),
    .rom_data_i(rom_data_i), .busy_o(busy_o), .done_o(done_o), .regs_we_acc_o(we_acc), .regs_we_aux_o(we_aux),
    .regs_o(regs_o), .load_second_timer_o(ld2), .load_third_timer_o(ld3), .load_fourth_timer_o(ld4),
    .load_cmp_ref_o(ldc), .load_data_o(load_data_o), .ptr_we_o(ptr_we_o), .ptr_o(ptr_o), .rom_rd_o(rom_rd_o),
    .rom_addr_o(rom_addr_o), .stack_push_o(push), .stack_pop_o(pop));

  // ==========================================================
  // Clock, 20 ns period
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================
  // Issue one instruction, collect strobes until completion
  task automatic exec(input xfer_pkg::op_t op, input logic [7:0] r, input logic m);
    @(posedge sys_clk_i);
    op_valid_i <= 1'b1;
    op_i       <= op;
    regs_i     <= r;
    mode_sel   <= m;
    @(posedge sys_clk_i);
    op_valid_i <= 1'b0;
    lat = 0;
    n_push = 0;
    n_pop = 0;
    n_busy = 0;
    s_ld = 4'h0;
    do begin
      @(negedge sys_clk_i);
      lat++;
      if (push === 1'b1) n_push++;
      if (pop === 1'b1) n_pop++;
      if (busy_o === 1'b1) n_busy++;
      if (rom_rd_o === 1'b1) s_addr = rom_addr_o;
      s_ld = s_ld | {ld2, ld3, ld4, ldc};
    end while (done_o !== 1'b1 && lat < 8);
    s_we = {we_aux, we_acc};
    s_regs = regs_o;
    s_ldata = load_data_o;
    s_pwe = ptr_we_o;
    s_ptr = ptr_o;
  endtask

  // ==========================================================
  // Comparison helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_single(input logic [1:0] we, input logic [3:0] ld, input logic [7:0] v);
    chk(16'(lat), 16'h0001, "latency");
    chk(16'({n_busy[3:0], n_push[3:0], n_pop[3:0], 3'h0, s_pwe}), 16'h0000, "sequencer idle");
    chk(16'(s_ld), 16'(ld), "load strobes");
    chk(16'(s_we), 16'(we), "register writes");
    if (we[1]) chk(16'(s_regs[7:4]), 16'(v[7:4]), "aux value");
    if (we[0]) chk(16'(s_regs[3:0]), 16'(v[3:0]), "acc value");
    if (ld != 4'h0) chk(16'(s_ldata), 16'(v), "load data");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_loads();
    exec(xfer_pkg::OP_LOAD_T2, 8'hA5, 1'b0);
    chk_single(2'b00, 4'h8, 8'hA5);
    exec(xfer_pkg::OP_LOAD_T3, 8'h5A, 1'b0);
    chk_single(2'b00, 4'h4, 8'h5A);
    exec(xfer_pkg::OP_LOAD_T4, 8'hC3, 1'b1);
    chk_single(2'b00, 4'h2, 8'hC3);
    $display("test loads finished");
  endtask

  task automatic t_reads();
    exec(xfer_pkg::OP_COPY_AUX, 8'h3C, 1'b0);
    chk_single(2'b01, 4'h0, 8'h03);
    exec(xfer_pkg::OP_READ_T1, 8'h00, 1'b0);
    chk_single(2'b11, 4'h0, 8'h1E);
    exec(xfer_pkg::OP_READ_T2, 8'h00, 1'b0);
    chk_single(2'b11, 4'h0, 8'h2B);
    exec(xfer_pkg::OP_READ_T3, 8'h00, 1'b0);
    chk_single(2'b11, 4'h0, 8'h3C);
    exec(xfer_pkg::OP_READ_T4, 8'h00, 1'b0);
    chk_single(2'b11, 4'h0, 8'h4D);
    exec(xfer_pkg::OP_READ_EXT, 8'h00, 1'b0);
    chk_single(2'b11, 4'h0, 8'h7E);
    exec(xfer_pkg::OP_READ_SER, 8'h00, 1'b0);
    chk_single(2'b11, 4'h0, 8'h96);
    exec(xfer_pkg::OP_READ_PTR, 8'hFF, 1'b0);
    chk_single(2'b01, 4'h0, 8'h06);
    $display("test reads finished");
  endtask

  task automatic t_convert();
    exec(xfer_pkg::OP_READ_CONV, 8'h00, 1'b0);
    chk_single(2'b11, 4'h0, 8'hB5);
    exec(xfer_pkg::OP_READ_CONV, 8'h00, 1'b1);
    chk_single(2'b11, 4'h0, 8'hD6);
    exec(xfer_pkg::OP_WR_CMPREF, 8'h69, 1'b0);
    chk_single(2'b00, 4'h0, 8'h69);
    exec(xfer_pkg::OP_WR_CMPREF, 8'h69, 1'b1);
    chk_single(2'b00, 4'h1, 8'h69);
    $display("test converter finished");
  endtask

  task automatic t_rom();
    exec(xfer_pkg::OP_READ_ROM, 8'h59, 1'b0);
    chk(16'(lat), 16'h0004, "table read latency");
    chk(16'(n_push), 16'h0001, "stack pushes");
    chk(16'(n_pop), 16'h0001, "stack pops");
    chk(16'(n_busy), 16'h0003, "busy cycles");
    chk(16'(s_addr), 16'({6'h3F, 3'h6, 4'h9}), "table address");
    chk(16'({s_we, s_regs}), 16'({2'b11, 8'hB4}), "table data");
    chk(16'({s_pwe, s_ptr}), 16'({1'b1, 3'h2}), "pointer update");
    $display("test table read finished");
  endtask

  // ==========================================================
  // Verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // Main sequence
  initial begin
    mismatches = 0;
    tests_run = 0;
    sys_rst_i = 1'b1;
    op_valid_i = 1'b0;
    op_i = xfer_pkg::OP_LOAD_T2;
    regs_i = 8'h00;
    mode_sel = 1'b0;
    page_i = 6'h3F;
    ptr_i = 3'h6;
    rom_data_i = 10'h2B4;
    periph_i = {32'h4D3C2B1E, 10'h2D6, 8'h7E, 8'h96};
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_loads();
    t_reads();
    t_convert();
    t_rom();
    report_and_stop();
  end
endmodule
`default_nettype wire
